// File: hdl/sdsr_pkg.sv
/*
 * Constants for the self-refresh and full-page burst engine of a four-bank SDRAM.
 * Assumes a single 40 MHz clock and commands sampled on its rising edge.
 */
// Summary of operation
// - One cycle after entry every input except CKE is ignored and the clock may stop.
// - The device stays in self refresh while CKE is low and leaves only when CKE is sampled high.
// - A full-page burst never stops on its own and moves one column per cycle.
// - A full-page burst wraps from the highest column to column zero and continues.
package sdsr_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   localparam int TRC_PS        = 60000;
   localparam int TIS_PS        = 1500;
   localparam int TXSR_CYC      = (TRC_PS + TIS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int NUM_COLS      = 256;
   localparam int NUM_BANKS     = 4;

   // ----------------------------------------------------------------
   // Command encodings {ras_n, cas_n, we_n}
   // ----------------------------------------------------------------
   localparam logic [2:0] CMD_ACT  = 3'h3;
   localparam logic [2:0] CMD_RD   = 3'h5;
   localparam logic [2:0] CMD_WR   = 3'h4;
   localparam logic [2:0] CMD_BST  = 3'h6;
   localparam logic [2:0] CMD_PRE  = 3'h2;
   localparam logic [2:0] CMD_REF  = 3'h1;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_BURST = 4'b0010,
      ST_SELF  = 4'b0100,
      ST_EXIT  = 4'b1000
   } sdsr_state_t;
endpackage : sdsr_pkg

// File: hdl/sdsr_core.sv
/*
 * Device-side command engine: self-refresh entry/retention/exit and
 * full-page burst column counter with wrap.
 * Assumes the controller keeps its own timing (entry hold, exit wait),
 * its own refresh schedule around self refresh, and ends every
 * full-page burst itself; data pins and row state live elsewhere.
 * All pins are synchronous to the one reference clock.
 * The controller may hold the clock low in self refresh; the engine
 * needs it running again before CKE is raised.
 * Outputs are status only (flags, burst bank and column) and change on the rising edge.
 * Reset is synchronous and active high.
 */
`timescale 1ns/1ps
`default_nettype none
module sdsr_core #(
   parameter int COL_W = 8
) (
   input  wire logic             I_REF_CLK,
   input  wire logic             I_RESET,
   input  wire logic             I_CKE,
   input  wire logic             I_CS_N,
   input  wire logic             I_RAS_N,
   input  wire logic             I_CAS_N,
   input  wire logic             I_WE_N,
   input  wire logic [1:0]       I_BA,
   input  wire logic [COL_W-1:0] I_COL,
   output logic                  o_SELF_REFRESH,
   output logic                  o_EXIT_BUSY,
   output logic                  o_BURST_ACTIVE,
   output logic                  o_BURST_WRITE,
   output logic [1:0]            o_BURST_BANK,
   output logic [COL_W-1:0]      o_BURST_COL,
   output logic                  o_COL_WRAP
);
   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   // The wrap point is the last column of the open row, so the
   // column counter must be exactly as wide as the column address.
   if ((1 << COL_W) != sdsr_pkg::NUM_COLS) begin : g_bad_col_w
      $error("COL_W must match the column count");
   end

   // The exit wait is counted in an eight-bit down counter
   if (sdsr_pkg::TXSR_CYC < 1 || sdsr_pkg::TXSR_CYC > 256) begin : g_bad_txsr
      $error("Exit time does not fit the exit counter");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   sdsr_pkg::sdsr_state_t state_q;
   sdsr_pkg::sdsr_state_t state_d;
   logic [7:0]            xcnt_q;
   logic [7:0]            xcnt_d;
   logic [COL_W-1:0]      col_q;
   logic [COL_W-1:0]      col_d;
   logic [1:0]            bank_q;
   logic [1:0]            bank_d;
   logic                  wr_q;
   logic                  wr_d;
   logic                  wrap_q;
   logic                  wrap_d;
   logic                  sr_q;
   logic                  sr_d;
   logic                  xb_q;
   logic                  xb_d;
   logic                  act_q;
   logic                  act_d;
   logic [2:0]            cmd_bits;
   logic                  accept;
   logic                  self_ent;
   logic                  wr_cmd;
   logic                  col_cmd;
   logic                  stop_cmd;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   function automatic logic is_cmd(input logic       cs_n,
                                   input logic [2:0] bits,
                                   input logic [2:0] c);
      return !cs_n && (bits == c);
   endfunction : is_cmd

   assign cmd_bits = {I_RAS_N, I_CAS_N, I_WE_N};

   always_comb begin
      // Commands count only while neither in nor leaving self refresh
      accept   = (state_q == sdsr_pkg::ST_IDLE) || (state_q == sdsr_pkg::ST_BURST);
      // Refresh command sampled with CKE low enters self refresh
      self_ent = accept && !I_CKE && is_cmd(I_CS_N, cmd_bits, sdsr_pkg::CMD_REF);
      wr_cmd   = I_CKE && is_cmd(I_CS_N, cmd_bits, sdsr_pkg::CMD_WR);
      col_cmd  = accept && (wr_cmd || (I_CKE && is_cmd(I_CS_N, cmd_bits, sdsr_pkg::CMD_RD)));
      // Burst stop or precharge ends a full-page burst, as does self refresh entry
      stop_cmd = accept && I_CKE && (is_cmd(I_CS_N, cmd_bits, sdsr_pkg::CMD_BST)
                                     || is_cmd(I_CS_N, cmd_bits, sdsr_pkg::CMD_PRE));
   end

   // ----------------------------------------------------------------
   // Operating state and exit wait
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      xcnt_d  = xcnt_q;
      case (state_q)
         sdsr_pkg::ST_IDLE: begin
            if (self_ent) begin
               state_d = sdsr_pkg::ST_SELF;
            end else if (col_cmd) begin
               state_d = sdsr_pkg::ST_BURST;
            end
         end
         sdsr_pkg::ST_BURST: begin
            // Left only on an explicit command, never on a count
            if (self_ent) begin
               state_d = sdsr_pkg::ST_SELF;
            end else if (stop_cmd) begin
               state_d = sdsr_pkg::ST_IDLE;
            end
         end
         sdsr_pkg::ST_SELF: begin
            // All inputs but CKE ignored; stay until CKE high
            if (I_CKE) begin
               state_d = sdsr_pkg::ST_EXIT;
               xcnt_d  = 8'(sdsr_pkg::TXSR_CYC - 1);
            end
         end
         sdsr_pkg::ST_EXIT: begin
            // Commands during the exit window are not acted on
            if (xcnt_q == 8'h00) begin
               state_d = sdsr_pkg::ST_IDLE;
            end else begin
               xcnt_d = xcnt_q - 8'h01;
            end
         end
         default: begin
            state_d = sdsr_pkg::ST_IDLE;
            xcnt_d  = 8'h00;
         end
      endcase
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         state_q <= sdsr_pkg::ST_IDLE;
         xcnt_q  <= 8'h00;
      end else begin
         state_q <= state_d;
         xcnt_q  <= xcnt_d;
      end
   end

   // ----------------------------------------------------------------
   // Full-page column counter
   // ----------------------------------------------------------------
   // A new read or write restarts the counter at its own column; a
   // suspended clock (CKE low without refresh) does not hold it.
   always_comb begin
      col_d  = col_q;
      bank_d = bank_q;
      wr_d   = wr_q;
      wrap_d = 1'b0;
      if (col_cmd) begin
         col_d  = I_COL;
         bank_d = I_BA;
         wr_d   = wr_cmd;
      end else if (state_q == sdsr_pkg::ST_BURST && !self_ent && !stop_cmd) begin
         // Never self-terminates; wraps at the last column
         col_d  = COL_W'(col_q + 1'b1);
         wrap_d = &col_q;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         col_q  <= '0;
         bank_q <= 2'h0;
         wr_q   <= 1'b0;
         wrap_q <= 1'b0;
      end else begin
         col_q  <= col_d;
         bank_q <= bank_d;
         wr_q   <= wr_d;
         wrap_q <= wrap_d;
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   // Decoded from the next state so the pins move on the same edge as
   // the state register while still coming straight from flip-flops.
   always_comb begin
      sr_d  = state_d == sdsr_pkg::ST_SELF;
      xb_d  = state_d == sdsr_pkg::ST_EXIT;
      act_d = state_d == sdsr_pkg::ST_BURST;
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         sr_q  <= 1'b0;
         xb_q  <= 1'b0;
         act_q <= 1'b0;
      end else begin
         sr_q  <= sr_d;
         xb_q  <= xb_d;
         act_q <= act_d;
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   assign o_SELF_REFRESH = sr_q;
   assign o_EXIT_BUSY    = xb_q;
   assign o_BURST_ACTIVE = act_q;
   assign o_BURST_WRITE  = wr_q;
   assign o_BURST_BANK   = bank_q;
   assign o_BURST_COL    = col_q;
   assign o_COL_WRAP     = wrap_q;
endmodule : sdsr_core
`default_nettype wire

// File: bench/sdsr_core_checker.sv
/* Port checker for sdsr_core.
   Assumes commands are sampled on the rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module sdsr_core_checker #(
   parameter int COL_W = 8
) (
   input wire logic             I_REF_CLK,
   input wire logic             I_RESET,
   input wire logic             I_CKE,
   input wire logic             I_CS_N,
   input wire logic             I_RAS_N,
   input wire logic             I_CAS_N,
   input wire logic             I_WE_N,
   input wire logic             o_SELF_REFRESH,
   input wire logic             o_EXIT_BUSY,
   input wire logic             o_BURST_ACTIVE,
   input wire logic [COL_W-1:0] o_BURST_COL
);
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RESET);
   wire logic [2:0] cmd = {I_RAS_N, I_CAS_N, I_WE_N};
   wire logic quiet = I_CKE && (I_CS_N || cmd == 3'h7);
   wire logic idle = !o_SELF_REFRESH && !o_EXIT_BUSY && !o_BURST_ACTIVE;
   a_sr_entry_seen: assert property (idle && !I_CKE && !I_CS_N && cmd == sdsr_pkg::CMD_REF
      |=> o_SELF_REFRESH) else $error("self refresh not entered");
   a_sr_retain: assert property (o_SELF_REFRESH && !I_CKE |=> o_SELF_REFRESH)
      else $error("self refresh left with clock enable low");
   a_sr_leave: assert property (o_SELF_REFRESH && I_CKE |-> ##[1:2] !o_SELF_REFRESH)
      else $error("self refresh kept after clock enable high");
   a_exit_len: assert property ($rose(o_EXIT_BUSY) |-> o_EXIT_BUSY ##1 o_EXIT_BUSY
      ##1 o_EXIT_BUSY ##1 !o_EXIT_BUSY) else $error("exit window length wrong");
   a_burst_col_step: assert property (o_BURST_ACTIVE && quiet |=> o_BURST_ACTIVE
      && o_BURST_COL == COL_W'($past(o_BURST_COL) + 1'b1))
      else $error("burst column did not advance by one");
   c_sr: cover property (o_SELF_REFRESH ##1 I_CKE);
   c_wrap: cover property (o_BURST_ACTIVE && o_BURST_COL == '1 ##1 o_BURST_COL == '0);
   c_exit: cover property ($fell(o_EXIT_BUSY));
endmodule : sdsr_core_checker
bind sdsr_core sdsr_core_checker #(.COL_W(COL_W)) u_chk (.I_REF_CLK(I_REF_CLK),
   .I_RESET(I_RESET), .I_CKE(I_CKE), .I_CS_N(I_CS_N), .I_RAS_N(I_RAS_N),
   .I_CAS_N(I_CAS_N), .I_WE_N(I_WE_N), .o_SELF_REFRESH(o_SELF_REFRESH),
   .o_EXIT_BUSY(o_EXIT_BUSY), .o_BURST_ACTIVE(o_BURST_ACTIVE), .o_BURST_COL(o_BURST_COL));
`default_nettype wire

// File: bench/sdsr_ctrl_model.sv
/* Memory controller model driving commands at the falling edge.
   Assumes the bench supplies a free running clock. */
`timescale 1ns/1ps
`default_nettype none
module sdsr_ctrl_model (
   input  wire logic i_clk,
   output logic      o_cke,
   output logic      o_cs_n,
   output logic [2:0] o_cmd,
   output logic [1:0] o_ba,
   output logic [7:0] o_col
);
   initial begin
      o_cke = 1'b1;
      o_cs_n = 1'b1;
      o_cmd = 3'h7;
      o_ba = 2'h0;
      o_col = 8'h00;
   end
   task automatic issue(input logic [2:0] cmd, input logic [1:0] ba, input logic [7:0] col);
      @(negedge i_clk);
      {o_cs_n, o_cmd, o_ba, o_col} = {1'b0, cmd, ba, col};
      @(negedge i_clk);
      {o_cs_n, o_cmd, o_col} = {1'b1, 3'h7, ~col};
   endtask : issue
   // Auto refreshes, one every second cycle with a deselect cycle between
   task automatic auto_refresh(input int n);
      repeat (n) issue(sdsr_pkg::CMD_REF, 2'h0, 8'h00);
   endtask : auto_refresh
   // Hold must cover 40/42 ns row-active minimum: n of at least 2 cycles
   task automatic self_refresh(input int n);
      @(negedge i_clk);
      {o_cke, o_cs_n, o_cmd} = {1'b0, 1'b0, sdsr_pkg::CMD_REF};
      repeat (n) begin
         @(negedge i_clk);
         {o_cs_n, o_cmd, o_col} = {~o_cs_n, ~o_cmd, ~o_col}; // Undriven lines wander
      end
      @(negedge i_clk);
      {o_cke, o_cs_n, o_cmd} = {1'b1, 1'b1, 3'h7}; // Clock already running
      repeat (sdsr_pkg::TXSR_CYC + 1) @(negedge i_clk); // Only deselect meanwhile
   endtask : self_refresh
endmodule : sdsr_ctrl_model
`default_nettype wire

// File: bench/sdsr_self_refresh_fullpage_tb_top.sv
/* Bench for sdsr_core: self refresh round trip and full-page wrap.
   Assumes 40 MHz clock and the controller model beside it. */
`timescale 1ns/1ps
`default_nettype none
module sdsr_self_refresh_fullpage_tb_top;
   logic clk = 1'b0, rst = 1'b1, cke, cs_n, sr, xb, act, wr, wrap;
   logic [2:0] cmd;
   logic [1:0] ba, bank;
   logic [7:0] col, bcol;
   int failures = 0, n_compared = 0;
   initial forever #12.5 clk = ~clk;
   sdsr_ctrl_model ctl (.i_clk(clk), .o_cke(cke), .o_cs_n(cs_n), .o_cmd(cmd), .o_ba(ba), .o_col(col));
   sdsr_core #(.COL_W(8)) dut (.I_REF_CLK(clk), .I_RESET(rst), .I_CKE(cke), .I_CS_N(cs_n),
      .I_RAS_N(cmd[2]), .I_CAS_N(cmd[1]), .I_WE_N(cmd[0]), .I_BA(ba), .I_COL(col),
      .o_SELF_REFRESH(sr), .o_EXIT_BUSY(xb), .o_BURST_ACTIVE(act), .o_BURST_WRITE(wr),
      .o_BURST_BANK(bank), .o_BURST_COL(bcol), .o_COL_WRAP(wrap));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test;
      if (failures == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   task automatic t_self_refresh;
      fork ctl.self_refresh(6); join_none
      repeat (5) @(negedge clk);
      check(sr, 1'b1);
      repeat (5) @(negedge clk);
      check({sr, xb}, 2'b01);
      wait fork;
      check({sr, xb}, 2'b00);
   endtask : t_self_refresh
   task automatic t_burst(input logic [2:0] c, input logic [1:0] b, input logic [3:0] e);
      int k;
      ctl.issue(sdsr_pkg::CMD_ACT, b, 8'h00);
      ctl.issue(c, b, 8'hFD);
      for (k = 0; k < 8 && bcol !== 8'hFF; k++) @(negedge clk);
      if (k == 8) begin failures++; end_of_test(); end
      @(negedge clk);
      check({act, wr, bank, wrap, bcol}, {e, 1'b1, 8'h00});
      repeat (300) @(negedge clk);
      check({act, bcol}, {1'b1, 8'h2C});
      ctl.issue(c == sdsr_pkg::CMD_WR ? sdsr_pkg::CMD_BST : sdsr_pkg::CMD_PRE, b, 8'h00);
      repeat (2) @(negedge clk);
      check(act, 1'b0);
   endtask : t_burst
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      ctl.auto_refresh(4096);
      check({sr, xb, act}, 3'b000);
      t_self_refresh();
      ctl.auto_refresh(4096);
      check({sr, xb, act}, 3'b000);
      t_burst(sdsr_pkg::CMD_WR, 2'h2, 4'b1110);
      t_burst(sdsr_pkg::CMD_RD, 2'h1, 4'b1001);
      end_of_test();
   end
endmodule : sdsr_self_refresh_fullpage_tb_top
`default_nettype wire
